// >>> bench/gpc_pins.sv
// board side of the port pins: resolves each pad from driver, outside source and pulls
// assumes the bench steers the outside source through ext_en_i and ext_val_i
`default_nettype none
module gpc_pins (
  input  wire logic       clk_i,      // same clock as the port
  input  wire logic [7:0] pad_o_i,    // port output value
  input  wire logic [7:0] pad_oe_i,   // port drives pin
  input  wire logic [7:0] pull_en_i,  // internal pull on
  input  wire logic [7:0] pull_up_i,  // pull direction
  input  wire logic [7:0] ext_en_i,   // outside source drives pin
  input  wire logic [7:0] ext_val_i,  // outside source level
  output logic      [7:0] pad_i_o     // resolved pin level
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] last_q = 8'h00; // last level some source put on the pin
  logic [7:0] held_w;         // pin has a driver, outside source or pull
  ////////////////////////////////////////////////////////////////////////////////
  // outside source holds its level as long as the bench keeps it
  // a pin with no source at all shows the inverse of the level last put on it
  assign held_w = pad_oe_i | ext_en_i | pull_en_i;
  always @(posedge clk_i) last_q <= (held_w & pad_i_o) | (~held_w & last_q);
  assign pad_i_o = (pad_oe_i & pad_o_i) | (~pad_oe_i & ext_en_i & ext_val_i)
                 | (~pad_oe_i & ~ext_en_i & ((pull_en_i & pull_up_i) | (~pull_en_i & ~last_q)));
endmodule // gpc_pins
`default_nettype wire

// >>> bench/gpc_port_tb_top.sv
// self-checking bench of the eight-pin port: registers, drive modes, sensing, sleep
// assumes the port package map and the pin model on the far side
`default_nettype none
module gpc_port_tb_top
  import gpc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk_i, arst_n_i, we_i, re_i, clk_run_i, wake_o; // clock, reset, strobes
  logic [4:0] addr_i;                                         // register address
  logic [7:0] wdata_i, rdata_o, pad_o, pad_oe, pen, pup, ext_en, ext_val, pad_w, d;
  logic [1:0] irq;                                            // vector requests
  int         failures, samples_checked;
  gpc_port DUT (.clk_i(clk_i), .arst_n_i(arst_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .we_i(we_i),
    .re_i(re_i), .rdata_o(rdata_o), .clk_run_i(clk_run_i), .pad_i(pad_w), .pad_o(pad_o),
    .pad_oe_o(pad_oe), .pad_pull_en_o(pen), .pad_pull_up_o(pup), .wake_o(wake_o), .pad_irq_request_o(irq));
  gpc_pins pins (.clk_i(clk_i), .pad_o_i(pad_o), .pad_oe_i(pad_oe), .pull_en_i(pen), .pull_up_i(pup),
    .ext_en_i(ext_en), .ext_val_i(ext_val), .pad_i_o(pad_w));
  ////////////////////////////////////////////////////////////////////////////////
  // shared tasks
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    samples_checked++;
    if (s !== e) begin
      failures++;
      $display("MISMATCH %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] v);
    @(posedge clk_i);
    addr_i <= a; wdata_i <= v; we_i <= 1'b1;
    @(posedge clk_i);
    we_i <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a);
    @(posedge clk_i);
    addr_i <= a; re_i <= 1'b1;
    @(posedge clk_i);
    re_i <= 1'b0;
    #1 d = rdata_o;
  endtask
  task automatic pin(input logic [7:0] en, input logic [7:0] v);
    @(posedge clk_i);
    ext_en <= en; ext_val <= v;
  endtask
  task automatic wrap_up;
    if (failures == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic s_regs; // direction set/clear/toggle, drive, unmapped read
    wr(GPC_OFF_WAY, 8'h0f); wr(GPC_OFF_WAY + 5'h01, 8'h30); wr(GPC_OFF_WAY + 5'h02, 8'h03);
    wr(GPC_OFF_WAY + 5'h03, 8'h81); wr(GPC_OFF_DRIVE, 8'ha5); tick(2);
    chk(pad_oe, 8'hbd);
    chk(pad_o & pad_oe, 8'ha5 & 8'hbd);
    rd(GPC_OFF_WAY + 5'h02); chk(d, 8'hbd);
    rd(5'h1f); chk(d, 8'h00);
  endtask
  task automatic s_level; // read-back in both directions, disabled input
    wr(GPC_OFF_WAY, 8'hf0); pin(8'h0f, 8'h0a); tick(4);
    rd(GPC_OFF_LEVEL); chk(d, 8'haa);
    wr(GPC_OFF_CFG_BASE + 5'h01, {5'h00, GPC_SENSE_OFF}); tick(4);
    rd(GPC_OFF_LEVEL); chk(d, 8'ha8);
    wr(GPC_OFF_CFG_BASE + 5'h01, 8'h00);
  endtask
  task automatic s_modes; // every mode, both directions, both drive values on pin 1
    logic [2:0] m; logic oe_e, pen_e;
    for (int k = 0; k < 32; k++) begin
      m = k[4:2];
      pin({6'h00, ~k[1], 1'b0}, {8{k[0]}}); wr(GPC_OFF_CFG_BASE + 5'h01, {2'b00, m, 3'b000});
      wr(GPC_OFF_WAY, {6'h00, k[1], 1'b0}); wr(GPC_OFF_DRIVE, {8{k[0]}}); tick(4);
      oe_e = m[2] ? (k[1] & (k[0] ^ m[0])) : k[1];
      pen_e = m[2] ? m[1] : ((m == 3'h1) | (m[1] & ~k[1]));
      chk({5'h00, pad_oe[1], pen[1], pen[1] & pup[1]},
          {5'h00, oe_e, pen_e, pen_e & ((m == 3'h1) ? k[0] : m[0])});
    end
    wr(GPC_OFF_CFG_BASE + 5'h01, 8'h00);
  endtask
  task automatic s_inv; // inverted input and output on pin 4
    wr(GPC_OFF_CFG_BASE + 5'h04, 8'h40); wr(GPC_OFF_WAY, 8'h00); pin(8'h10, 8'h10); tick(4);
    rd(GPC_OFF_LEVEL); chk(d & 8'h10, 8'h00);
    wr(GPC_OFF_WAY, 8'h10); wr(GPC_OFF_DRIVE, 8'h00); tick(2);
    chk(pad_o & 8'h10, 8'h10);
    wr(GPC_OFF_CFG_BASE + 5'h04, 8'h00); wr(GPC_OFF_WAY, 8'h00);
  endtask
  task automatic s_sense; // edge codes with exact latency, low level, vector enable
    wr(GPC_OFF_MASK0, 8'h01); wr(GPC_OFF_MASK1, 8'h01); wr(GPC_OFF_IRQ_EN, 8'h01);
    for (int c = 0; c < 3; c++) begin
      wr(GPC_OFF_CFG_BASE, c[7:0]); pin(8'h01, 8'h00); tick(5); wr(GPC_OFF_FLAGS, 8'h03); tick(2);
      pin(8'h01, 8'h01); tick(2); chk({7'h00, irq[0]}, 8'h00);
      tick(1); chk({7'h00, irq[0]}, {7'h00, c != 2});
      wr(GPC_OFF_FLAGS, 8'h03); tick(2); pin(8'h01, 8'h00); tick(3);
      chk({7'h00, irq[0]}, {7'h00, c != 1});
    end
    wr(GPC_OFF_CFG_BASE, {5'h00, GPC_SENSE_LOW}); tick(4); // pin held low throughout
    wr(GPC_OFF_FLAGS, 8'h03); tick(2);
    chk({6'h00, irq}, 8'h01);
    wr(GPC_OFF_IRQ_EN, 8'h03); tick(3); chk({6'h00, irq}, 8'h03);
    pin(8'h01, 8'h01); tick(4); wr(GPC_OFF_FLAGS, 8'h03); tick(2); chk({6'h00, irq}, 8'h00);
  endtask
  task automatic s_sleep; // clockless sensing on pin 3 and pin 2
    wr(GPC_OFF_MASK0, 8'h04); wr(GPC_OFF_MASK1, 8'h08); wr(GPC_OFF_CFG_BASE + 5'h02, 8'h01);
    wr(GPC_OFF_CFG_BASE + 5'h03, 8'h00); pin(8'h0c, 8'h00); tick(5); wr(GPC_OFF_FLAGS, 8'h03);
    @(posedge clk_i) clk_run_i <= 1'b0;
    pin(8'h0c, 8'h08); tick(4); chk({7'h00, wake_o}, 8'h01);
    pin(8'h0c, 8'h00); tick(4); @(posedge clk_i) clk_run_i <= 1'b1;
    tick(4); chk({6'h00, irq}, 8'h00);
    @(posedge clk_i) clk_run_i <= 1'b0;
    pin(8'h0c, 8'h04); tick(5);
    chk({6'h00, irq, wake_o}, 8'h03);
    @(posedge clk_i) clk_run_i <= 1'b1;
  endtask
  task automatic s_reset_mid; // reset tri-states at once, between edges
    wr(GPC_OFF_WAY, 8'hff); tick(2);
    #2 arst_n_i = 1'b0;
    #1 chk(pad_oe | pen, 8'h00);
    tick(2); arst_n_i <= 1'b1;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    arst_n_i = 1'b0; we_i = 1'b0; re_i = 1'b0; clk_run_i = 1'b1; addr_i = 5'h00;
    wdata_i = 8'h00; ext_en = 8'h00; ext_val = 8'h00; failures = 0; samples_checked = 0;
    repeat (6) @(posedge clk_i);
    arst_n_i <= 1'b1;
    tick(1); chk(pad_oe | pen, 8'h00);
    s_regs; s_level; s_modes; s_inv; s_sense; s_sleep; s_reset_mid;
    wrap_up;
  end
endmodule // gpc_port_tb_top
`default_nettype wire

// >>> hdl/gpc_port.sv
// eight-pin general-purpose port: direction, drive, pull modes, sampled levels,
// input sensing and two maskable interrupt vectors
// assumes pad_i comes from pins (synchronised here); clk_run_i is on-chip logic
// on clk_i that is high while the peripheral clock is present (low in sleep)
`default_nettype none

// Functional notes
// - direction bit one means output
// - drive bit sets output pin level
// - level readable both directions unless disabled
// - reset tri-states every pin at once
// - config picks totem, wired-and, wired-or, inversion
// - totem pulls only on input; plain floats
// - bus-keeper active in both directions
// - keeper pulls toward last pin level
// - wired modes keep pull in both directions
// - wired-or drives high, releases on zero
// - wired-or pull-down stays on as input
// - wired-and drives low, releases on one
// - wired-and pull-up stays on as input
// - input passes flop then level register
// - rise, fall, any-edge, low sensing raise requests
// - synchronous needs clock; clockless sensing wakes device
// - two vectors, own pin masks, need enable
// - synchronous edges sampled once before request
// - pin two latches every edge clocklessly
// - other pins clockless: any-edge, low only
// - low level requests while low, persist
module gpc_port
  import gpc_pkg::*;
(
  input  wire logic             clk_i,               // 125 MHz
  input  wire logic             arst_n_i,            // async reset, active low
  input  wire logic [4:0]       addr_i,              // register address
  input  wire logic [7:0]       wdata_i,             // write data
  input  wire logic             we_i,                // write strobe
  input  wire logic             re_i,                // read strobe
  output logic      [7:0]       rdata_o,             // read data, cycle after re_i
  input  wire logic             clk_run_i,           // peripheral clock present
  input  wire logic [7:0]       pad_i,               // pin levels
  output logic      [7:0]       pad_o,               // pin output value
  output logic      [7:0]       pad_oe_o,            // pin driven when high
  output logic      [7:0]       pad_pull_en_o,       // internal pull on
  output logic      [7:0]       pad_pull_up_o,       // pull toward high when set
  output logic                  wake_o,              // wake request while asleep
  output logic      [1:0]       pad_irq_request_o    // vector requests
);

  ////////////////////////////////////////////////////////////////////////////////
  // set, clear and toggle access on a byte register
  function automatic logic [7:0] gpc_rmw(input logic [7:0] cur, input logic [7:0] w, input logic [1:0] op);
    unique case (op)
      2'h0: gpc_rmw = w;                            // plain write
      2'h1: gpc_rmw = cur | w;                      // set
      2'h2: gpc_rmw = cur & ~w;                     // clear
      2'h3: gpc_rmw = cur ^ w;                      // toggle
    endcase
  endfunction

  // wired-and or wired-or code
  function automatic logic gpc_wired(input logic [2:0] mode);
    gpc_wired = mode[2];
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // registers
  logic [7:0] pad_way_q;                            // direction bits
  logic [7:0] pad_drive_q;                          // drive value bits
  logic [7:0] per_pad_config_q [GPC_PADS];          // per-pad config
  logic [1:0] irq_en_q;                             // vector enables
  logic [7:0] irq_mask_q [2];                       // vector pin masks
  logic [1:0] irq_flag_q;                           // pending flags
  logic [7:0] sync_q;                               // first synchroniser stage
  logic [7:0] level_q;                              // sampled-level register
  logic [7:0] sense_prev_q;                         // sense value one cycle back
  logic [7:0] snap_q;                               // sense value at sleep entry
  logic       run_prev_q;                           // clk_run_i one cycle back
  logic [7:0] rdata_q;
  logic [7:0] pad_q, pad_oe_q, pull_en_q, pull_up_q;
  logic       wake_q;
  logic [1:0] irq_q;

  ////////////////////////////////////////////////////////////////////////////////
  // write decode
  wire        wr_way   = we_i && (addr_i[4:2] == GPC_OFF_WAY[4:2]);
  wire        wr_drive = we_i && (addr_i[4:2] == GPC_OFF_DRIVE[4:2]);
  wire        wr_en    = we_i && (addr_i == GPC_OFF_IRQ_EN);
  wire        wr_m0    = we_i && (addr_i == GPC_OFF_MASK0);
  wire        wr_m1    = we_i && (addr_i == GPC_OFF_MASK1);
  wire        wr_flag  = we_i && (addr_i == GPC_OFF_FLAGS);
  wire        wr_cfg   = we_i && (addr_i[4:3] == GPC_OFF_CFG_BASE[4:3]);
  wire [7:0]  way_d    = wr_way ? gpc_rmw(pad_way_q, wdata_i, addr_i[1:0]) : pad_way_q;
  wire [7:0]  drive_d  = wr_drive ? gpc_rmw(pad_drive_q, wdata_i, addr_i[1:0]) : pad_drive_q;
  wire        run_rise = clk_run_i && !run_prev_q;  // wake-up has ended

  ////////////////////////////////////////////////////////////////////////////////
  // per-pin decode
  logic [7:0] inv_w, dis_w, sense_w, hit_w, wake_pin_w, level_view_w;
  logic [7:0] oe_d, o_d, pen_d, pup_d;
  logic [7:0] tot_w, keep_w, putot_w, wor_w, wand_w, wpull_w;

  for (genvar n = 0; n < GPC_PADS; n++) begin : g_pin
    wire [2:0] sense_sel = per_pad_config_q[n][GPC_CFG_SENSE_LSB +: 3];
    wire [2:0] mode      = per_pad_config_q[n][GPC_CFG_MODE_LSB +: 3];
    wire       drv       = pad_drive_q[n] ^ inv_w[n];
    wire       rise      = sense_w[n] && !sense_prev_q[n];
    wire       fall      = !sense_w[n] && sense_prev_q[n];
    wire       full      = (n == GPC_FULL_N);
    wire       edge_ok   = clk_run_i || full;
    wire       is_any    = (sense_sel == GPC_SENSE_ANY);
    wire       is_low    = (sense_sel == GPC_SENSE_LOW);
    wire       edge_hit  = (is_any && (rise || fall)) ||
                           ((sense_sel == GPC_SENSE_RISE) && rise) ||
                           ((sense_sel == GPC_SENSE_FALL) && fall);
    // clockless any-edge on a limited pin only counts if the change outlived wake-up
    wire       late_hit  = !full && run_rise && is_any && (sense_w[n] != snap_q[n]);
    assign inv_w[n]        = per_pad_config_q[n][GPC_CFG_INV_BIT];
    assign dis_w[n]        = (sense_sel == GPC_SENSE_OFF);
    assign sense_w[n]      = (level_q[n] ^ inv_w[n]) && !dis_w[n];
    assign level_view_w[n] = sense_w[n];
    // low level requests only while clocked, so it must persist past wake-up
    assign hit_w[n]        = (edge_ok && edge_hit) || late_hit ||
                             (clk_run_i && is_low && !sense_w[n] && !dis_w[n]);
    // while asleep, any-edge or low on a pin in an enabled vector's mask wakes; request is decided later
    assign wake_pin_w[n]   = (is_any && (sense_w[n] != snap_q[n])) ||
                             (is_low && !sense_w[n] && !dis_w[n]);
    assign tot_w[n]   = !gpc_wired(mode);
    assign keep_w[n]  = (mode == GPC_MODE_KEEP);
    assign putot_w[n] = (mode == GPC_MODE_PDN) || (mode == GPC_MODE_PUP);
    assign wor_w[n]   = (mode == GPC_MODE_WOR) || (mode == GPC_MODE_WORPD);
    assign wand_w[n]  = (mode == GPC_MODE_WAND) || (mode == GPC_MODE_WANPU);
    assign wpull_w[n] = (mode == GPC_MODE_WORPD) || (mode == GPC_MODE_WANPU);
    // driver: totem follows direction, wired modes drive one level only
    assign oe_d[n] = tot_w[n] ? pad_way_q[n] :
                     wor_w[n] ? (pad_way_q[n] && drv) :
                                (pad_way_q[n] && !drv);
    assign o_d[n]  = tot_w[n] ? drv : wor_w[n];
    // pulls: totem pulls on input only, keeper and wired pulls always
    assign pen_d[n] = keep_w[n] || wpull_w[n] ||
                      (putot_w[n] && !pad_way_q[n]);
    assign pup_d[n] = keep_w[n] ? level_q[n] :
                      (mode == GPC_MODE_PUP) || (mode == GPC_MODE_WANPU);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // vector request logic
  logic [1:0] set_w;
  for (genvar k = 0; k < 2; k++) begin : g_vec
    assign set_w[k] = irq_en_q[k] && |(hit_w & irq_mask_q[k]);
  end
  // a new event beats a clear in the same cycle
  wire [1:0] flag_d  = (irq_flag_q & ~(wr_flag ? wdata_i[1:0] : GPC_RST_PAIR)) | set_w;
  wire [7:0] vec_pins = (irq_en_q[0] ? irq_mask_q[0] : GPC_RST_BYTE) |
                        (irq_en_q[1] ? irq_mask_q[1] : GPC_RST_BYTE);
  wire       wake_d  = !clk_run_i && ((|(wake_pin_w & vec_pins)) || (|(irq_flag_q & irq_en_q)));

  ////////////////////////////////////////////////////////////////////////////////
  // read mux
  wire [7:0] cfg_rd = per_pad_config_q[addr_i[2:0]];
  wire [7:0] rd_mux = (addr_i[4:2] == GPC_OFF_WAY[4:2])     ? pad_way_q :
                      (addr_i[4:2] == GPC_OFF_DRIVE[4:2])   ? pad_drive_q :
                      (addr_i == GPC_OFF_LEVEL)             ? level_view_w :
                      (addr_i == GPC_OFF_IRQ_EN)            ? {6'h00, irq_en_q} :
                      (addr_i == GPC_OFF_MASK0)             ? irq_mask_q[0] :
                      (addr_i == GPC_OFF_MASK1)             ? irq_mask_q[1] :
                      (addr_i == GPC_OFF_FLAGS)             ? {6'h00, irq_flag_q} :
                      (addr_i[4:3] == GPC_OFF_CFG_BASE[4:3]) ? {1'b0, cfg_rd[6:0]} :
                                                              GPC_RST_BYTE;

  ////////////////////////////////////////////////////////////////////////////////
  // software-visible registers
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pad_way_q   <= GPC_RST_BYTE;
      pad_drive_q <= GPC_RST_BYTE;
      irq_en_q    <= GPC_RST_PAIR;
      irq_mask_q  <= '{default: GPC_RST_BYTE};
      irq_flag_q  <= GPC_RST_PAIR;
      rdata_q     <= GPC_RST_BYTE;
    end else begin
      pad_way_q   <= way_d;
      pad_drive_q <= drive_d;
      if (wr_en) irq_en_q <= wdata_i[1:0];
      if (wr_m0) irq_mask_q[0] <= wdata_i;
      if (wr_m1) irq_mask_q[1] <= wdata_i;
      irq_flag_q  <= flag_d;
      rdata_q     <= re_i ? rd_mux : GPC_RST_BYTE;
    end
  end

  // per-pad config array
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      per_pad_config_q <= '{default: GPC_RST_BYTE};
    end else if (wr_cfg) begin
      per_pad_config_q[addr_i[2:0]] <= {1'b0, wdata_i[6:0]};
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // input synchroniser and sense history
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sync_q       <= GPC_RST_BYTE;
      level_q      <= GPC_RST_BYTE;
      sense_prev_q <= GPC_RST_BYTE;
      snap_q       <= GPC_RST_BYTE;
      run_prev_q   <= 1'b0;
    end else begin
      sync_q       <= pad_i;
      level_q      <= sync_q;
      sense_prev_q <= sense_w;
      if (clk_run_i) snap_q <= sense_w;             // frozen while asleep
      run_prev_q   <= clk_run_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // pin drivers and request outputs, all from flops
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pad_q     <= GPC_RST_BYTE;
      pad_oe_q  <= GPC_RST_BYTE;
      pull_en_q <= GPC_RST_BYTE;
      pull_up_q <= GPC_RST_BYTE;
      wake_q    <= 1'b0;
      irq_q     <= GPC_RST_PAIR;
    end else begin
      pad_q     <= o_d;
      pad_oe_q  <= oe_d;
      pull_en_q <= pen_d;
      pull_up_q <= pup_d;
      wake_q    <= wake_d;
      irq_q     <= flag_d & irq_en_q;
    end
  end

  assign rdata_o           = rdata_q;
  assign pad_o             = pad_q;
  assign pad_oe_o          = pad_oe_q;
  assign pad_pull_en_o     = pull_en_q;
  assign pad_pull_up_o     = pull_up_q;
  assign wake_o            = wake_q;
  assign pad_irq_request_o = irq_q;

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  property p_way_out;
    @(posedge clk_i) disable iff (!arst_n_i)
      1'b1 |=> ((pad_oe_o & $past(tot_w)) == ($past(pad_way_q) & $past(tot_w)));
  endproperty
  a_way_out: assert property (p_way_out) else $error("totem enable differs from direction");

  property p_drive_level;
    @(posedge clk_i) disable iff (!arst_n_i)
      1'b1 |=> ((pad_o & $past(tot_w)) == (($past(pad_drive_q) ^ $past(inv_w)) & $past(tot_w)));
  endproperty
  a_drive_level: assert property (p_drive_level) else $error("totem level differs from drive bit");

  property p_sync_delay;
    @(posedge clk_i) disable iff (!arst_n_i)
      $past(arst_n_i, 2) |-> (level_q == $past(pad_i, 2));
  endproperty
  a_sync_delay: assert property (p_sync_delay) else $error("sampled level not two cycles behind pin");

  property p_level_read;
    @(posedge clk_i) disable iff (!arst_n_i)
      (re_i && (addr_i == GPC_OFF_LEVEL)) |=> (rdata_o == $past(level_view_w));
  endproperty
  a_level_read: assert property (p_level_read) else $error("level read returns wrong value");

  property p_totem_pull;
    @(posedge clk_i) disable iff (!arst_n_i)
      1'b1 |=> ((pad_pull_en_o & $past(putot_w)) == (~$past(pad_way_q) & $past(putot_w)));
  endproperty
  a_totem_pull: assert property (p_totem_pull) else $error("totem pull not tied to input direction");

  property p_keeper;
    @(posedge clk_i) disable iff (!arst_n_i)
      1'b1 |=> (((pad_pull_en_o & $past(keep_w)) == $past(keep_w)) &&
                ((pad_pull_up_o & $past(keep_w)) == ($past(level_q) & $past(keep_w))));
  endproperty
  a_keeper: assert property (p_keeper) else $error("keeper not pulling to last level");

  property p_wired_or;
    @(posedge clk_i) disable iff (!arst_n_i)
      1'b1 |=> (((pad_oe_o & $past(wor_w)) ==
                 ($past(pad_way_q) & ($past(pad_drive_q) ^ $past(inv_w)) & $past(wor_w))) &&
                ((pad_o & $past(wor_w)) == $past(wor_w)));
  endproperty
  a_wired_or: assert property (p_wired_or) else $error("wired-or drive wrong");

  property p_wired_and;
    @(posedge clk_i) disable iff (!arst_n_i)
      1'b1 |=> (((pad_oe_o & $past(wand_w)) ==
                 ($past(pad_way_q) & ~($past(pad_drive_q) ^ $past(inv_w)) & $past(wand_w))) &&
                ((pad_o & $past(wand_w)) == 8'h00));
  endproperty
  a_wired_and: assert property (p_wired_and) else $error("wired-and drive wrong");

  property p_wired_pull;
    @(posedge clk_i) disable iff (!arst_n_i)
      1'b1 |=> ((pad_pull_en_o & $past(wpull_w)) == $past(wpull_w));
  endproperty
  a_wired_pull: assert property (p_wired_pull) else $error("wired pull dropped");

  property p_irq_enabled;
    @(posedge clk_i) disable iff (!arst_n_i)
      1'b1 |=> ((pad_irq_request_o & ~$past(irq_en_q)) == 2'h0);
  endproperty
  a_irq_enabled: assert property (p_irq_enabled) else $error("request from disabled vector");

  property p_hit_sets;
    @(posedge clk_i) disable iff (!arst_n_i)
      set_w[0] |=> (irq_flag_q[0] && pad_irq_request_o[0]);
  endproperty
  a_hit_sets: assert property (p_hit_sets) else $error("sensed event lost");

  property p_wake;
    @(posedge clk_i) disable iff (!arst_n_i)
      (!clk_run_i && |(irq_flag_q & irq_en_q)) |=> wake_o;
  endproperty
  a_wake: assert property (p_wake) else $error("pending request did not wake");

endmodule : gpc_port

`default_nettype wire

// >>> pkg/gpc_pkg.sv
// constants, field layouts and mode codes of the eight-pin general-purpose port
// assumes a single 125 MHz clock and the plain register port of the port core
`default_nettype none

package gpc_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // sizes
  localparam int unsigned GPC_PADS   = 8;             // pins per port
  localparam int unsigned GPC_AW     = 5;             // register address width
  localparam int unsigned GPC_FULL_N = 2;             // pin with full clockless sensing

  ////////////////////////////////////////////////////////////////////////////////
  // register offsets
  localparam logic [4:0] GPC_OFF_WAY      = 5'h00;     // direction, +1 set, +2 clear, +3 toggle
  localparam logic [4:0] GPC_OFF_DRIVE    = 5'h04;     // drive value, +1 set, +2 clear, +3 toggle
  localparam logic [4:0] GPC_OFF_LEVEL    = 5'h08;     // sampled pin levels, read only
  localparam logic [4:0] GPC_OFF_IRQ_EN   = 5'h09;     // bit k enables vector k
  localparam logic [4:0] GPC_OFF_MASK0    = 5'h0a;     // pins feeding vector 0
  localparam logic [4:0] GPC_OFF_MASK1    = 5'h0b;     // pins feeding vector 1
  localparam logic [4:0] GPC_OFF_FLAGS    = 5'h0c;     // pending flags, write one to clear
  localparam logic [4:0] GPC_OFF_CFG_BASE = 5'h10;     // per-pad config, pin n at base + n

  ////////////////////////////////////////////////////////////////////////////////
  // per-pad config field layout
  localparam int unsigned GPC_CFG_SENSE_LSB = 0;      // [2:0] sense selection
  localparam int unsigned GPC_CFG_MODE_LSB  = 3;      // [5:3] output and pull mode
  localparam int unsigned GPC_CFG_INV_BIT   = 6;      // inverted input and output

  // sense codes
  localparam logic [2:0] GPC_SENSE_ANY  = 3'h0;
  localparam logic [2:0] GPC_SENSE_RISE = 3'h1;
  localparam logic [2:0] GPC_SENSE_FALL = 3'h2;
  localparam logic [2:0] GPC_SENSE_LOW  = 3'h3;
  localparam logic [2:0] GPC_SENSE_OFF  = 3'h4;       // digital input disabled

  // output and pull mode codes
  localparam logic [2:0] GPC_MODE_TOTEM = 3'h0;       // push-pull, input floats
  localparam logic [2:0] GPC_MODE_KEEP  = 3'h1;       // push-pull with bus-keeper
  localparam logic [2:0] GPC_MODE_PDN   = 3'h2;       // push-pull, pull-down on input
  localparam logic [2:0] GPC_MODE_PUP   = 3'h3;       // push-pull, pull-up on input
  localparam logic [2:0] GPC_MODE_WOR   = 3'h4;       // wired-or, no pull
  localparam logic [2:0] GPC_MODE_WAND  = 3'h5;       // wired-and, no pull
  localparam logic [2:0] GPC_MODE_WORPD = 3'h6;       // wired-or with pull-down
  localparam logic [2:0] GPC_MODE_WANPU = 3'h7;       // wired-and with pull-up

  ////////////////////////////////////////////////////////////////////////////////
  // values after reset
  localparam logic [7:0] GPC_RST_BYTE = 8'h00;        // every register clears
  localparam logic [1:0] GPC_RST_PAIR = 2'h0;         // flags and enables

endpackage : gpc_pkg

`default_nettype wire
